/* File: ae_ring_peer.sv */
// Board side: token ring of other devices and pulled-up status bus
`timescale 1ns/1ps
module ae_ring_peer (
    input  wire logic       clk,
    input  wire logic       ring_on,
    input  wire logic [1:0] lag,
    input  wire logic       inject,
    input  wire logic       tok_from_dut,
    input  wire logic [7:0] bus,
    input  wire logic [7:0] bus_oe,
    output logic            tok_to_dut,
    output logic [7:0]      bus_wire
);
    logic [2:0] hops_r;
    // Other devices each hold the token a whole cycle
    always_ff @(posedge clk) begin
        hops_r <= {hops_r[1:0], tok_from_dut};
    end
    always_comb begin
        tok_to_dut = inject | (ring_on & ((lag == 2'h0) ? tok_from_dut
                     : hops_r[lag - 2'h1]));
        for (int i = 0; i < 8; i++) begin
            // Released bits read the pull-up, never the last value
            bus_wire[i] = bus_oe[i] ? bus[i] : 1'b1;
        end
    end
endmodule

/* File: ae_status_bus_pkg.sv */
// Types for the almost-empty status bus block
package ae_status_bus_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DIRECT,
        ST_POLL_WAIT,
        ST_POLL_OWN
    } bus_state_t;
endpackage

/* File: ae_status_bus_regs.svh */
// Constants for the almost-empty status bus block
`ifndef AE_STATUS_BUS_REGS_SVH
`define AE_STATUS_BUS_REGS_SVH
`define AE_BUS_WIDTH      8
`define AE_QUEUE_COUNT    16
`define AE_ADDR_WIDTH     6
`define AE_SECTOR_BIT     0
`define AE_ID_MSB         5
`define AE_ID_LSB         3
`define AE_SECTOR_FIRST   1'h0
`define AE_SECTOR_SECOND  1'h1
`define AE_BUS_RESET      8'hff
`define AE_MASTER_SLOTS   2'h3
`endif

/* File: almost_empty_flag_status_bus.sv */
// Almost-empty status bus of the read port, direct and polled modes
`timescale 1ns/1ps
`include "ae_status_bus_regs.svh"

//Function
//- Eight queue almost-empty bits on bus
//- Selected queue drives flag; valid is held high whenever out of reset
//- Mode low at reset selects direct
//- Eight or fewer queues map directly
//- Strobe edge captures address LSB sector
//- Bus shows new sector next cycle
//- Sector two maps queues eight-fifteen
//- Coincident access may lag one cycle
//- Sector selection allowed every cycle
//- Top address bits must match identity
//- Mode high selects polled sector rotation
//- Sync high during first sector
//- Master takes bus after reset
//- Owner holds bus four cycles; others tristate
//- Pass token after cycling sectors
//- Single device still needs token
module almost_empty_flag_status_bus #(
    parameter int QUEUES = `AE_QUEUE_COUNT
) (
    input  wire logic                      CLK,
    input  wire logic                      RESET_N,
    input  wire logic                      MASTER_RESET_IN,
    input  wire logic                      FLAG_BUS_MODE_SELECT,
    input  wire logic                      CHAIN_MASTER_SELECT,
    input  wire logic                      DEVICE_IDENTITY_BIT0,
    input  wire logic                      DEVICE_IDENTITY_BIT1,
    input  wire logic                      DEVICE_IDENTITY_BIT2,
    input  wire logic [4:0]                QUEUE_COUNT,
    input  wire logic [QUEUES-1:0]         QUEUE_ALMOST_EMPTY,
    input  wire logic [3:0]                READ_QUEUE_SEL,
    input  wire logic [`AE_ADDR_WIDTH-1:0] READ_ADDRESS_BUS,
    input  wire logic                      EMPTY_SECTOR_STROBE,
    input  wire logic                      EMPTY_TOKEN_IN,
    output logic [`AE_BUS_WIDTH-1:0]       ALMOST_EMPTY_STATUS_BUS,
    output logic [`AE_BUS_WIDTH-1:0]       ALMOST_EMPTY_STATUS_BUS_OE,
    output logic                           ACTIVE_ALMOST_EMPTY_FLAG,
    output logic                           OUTPUT_VALID_FLAG,
    output logic                           EMPTY_BUS_SYNC_OUT,
    output logic                           EMPTY_TOKEN_OUT
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Reset, mode, master-select and token pins pass two flops; the first is read by no logic
    // Identity straps too, so a live strap change cannot glitch a match
    logic [6:0] meta_r;
    logic [6:0] sync_r;
    logic [6:0] meta_nxt;
    logic       mrs_s;
    logic       mode_s;
    logic       chain_master_select_s;
    logic       tok_s;

    always_comb begin
        meta_nxt = {DEVICE_IDENTITY_BIT2, DEVICE_IDENTITY_BIT1,
                    DEVICE_IDENTITY_BIT0, EMPTY_TOKEN_IN,
                    CHAIN_MASTER_SELECT, FLAG_BUS_MODE_SELECT,
                    MASTER_RESET_IN};
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            meta_r <= 7'h0;
            sync_r <= 7'h0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= meta_r;
        end
    end

    assign mrs_s  = sync_r[0];
    assign mode_s = sync_r[1];
    assign chain_master_select_s = sync_r[2];
    assign tok_s  = sync_r[3];

    // ------------------------------------------------------------
    // Sector helpers
    // ------------------------------------------------------------
    function automatic logic [`AE_BUS_WIDTH-1:0] sector_bits(
        input logic [2*`AE_BUS_WIDTH-1:0] flags,
        input logic                       sector
    );
        sector_bits = sector ? flags[2*`AE_BUS_WIDTH-1:`AE_BUS_WIDTH]
                             : flags[`AE_BUS_WIDTH-1:0];
    endfunction

    logic [2*`AE_BUS_WIDTH-1:0] flags_all;
    logic [2:0]                 own_id;
    logic                       id_match;
    logic                       small_cfg;

    generate
        for (genvar g = 0; g < 2*`AE_BUS_WIDTH; g++) begin : g_pad
            if (g < QUEUES) begin : g_q
                assign flags_all[g] = QUEUE_ALMOST_EMPTY[g];
            end else begin : g_x
                // Unconfigured queues read as not almost empty
                assign flags_all[g] = 1'b1;
            end
        end
    endgenerate

    assign own_id = sync_r[6:4];
    assign id_match = READ_ADDRESS_BUS[`AE_ID_MSB:`AE_ID_LSB] == own_id;
    assign small_cfg = QUEUE_COUNT <= 5'(`AE_BUS_WIDTH);

    // ------------------------------------------------------------
    // Bus control state
    // ------------------------------------------------------------
    ae_status_bus_pkg::bus_state_t state_r;
    ae_status_bus_pkg::bus_state_t state_nxt;
    logic                     sector_r;
    logic                     sector_nxt;
    logic [1:0]               slot_r;
    logic [1:0]               slot_nxt;
    logic                     mrs_d_r;
    logic [`AE_BUS_WIDTH-1:0] bus_nxt;
    logic [`AE_BUS_WIDTH-1:0] oe_nxt;
    logic                     sync_nxt;
    logic                     tok_nxt;
    logic                     pae_nxt;
    logic                     ov_nxt;
    logic                     direct_sel;

    assign direct_sel = EMPTY_SECTOR_STROBE && id_match;

    always_comb begin
        state_nxt  = state_r;
        sector_nxt = sector_r;
        slot_nxt   = slot_r;
        sync_nxt   = 1'b0;
        tok_nxt    = 1'b0;
        oe_nxt     = '0;
        bus_nxt    = `AE_BUS_RESET;
        // Selected queue flag on dedicated pins
        pae_nxt    = flags_all[READ_QUEUE_SEL];
        ov_nxt     = 1'b0;
        if (mrs_s) begin
            // Mode is latched while reset is held
            state_nxt  = mode_s ? ae_status_bus_pkg::ST_POLL_WAIT
                                : ae_status_bus_pkg::ST_DIRECT;
            sector_nxt = `AE_SECTOR_FIRST;
            slot_nxt   = 2'h0;
        end else begin
            case (state_r)
                ae_status_bus_pkg::ST_DIRECT: begin
                    oe_nxt = '1;
                    if (direct_sel) begin
                        // New sector each cycle allowed
                        sector_nxt = READ_ADDRESS_BUS[`AE_SECTOR_BIT];
                    end
                    // Registered: bus follows one cycle later
                    // Eight or fewer queues ignore sector
                    bus_nxt = sector_bits(flags_all,
                                  small_cfg ? `AE_SECTOR_FIRST
                                            : sector_nxt);
                end
                ae_status_bus_pkg::ST_POLL_WAIT: begin
                    // Master starts after reset; others need token
                    if ((chain_master_select_s && mrs_d_r) || tok_s) begin
                        state_nxt  = ae_status_bus_pkg::ST_POLL_OWN;
                        sector_nxt = `AE_SECTOR_SECOND;
                        slot_nxt   = 2'h0;
                        oe_nxt     = '1;
                        sync_nxt   = 1'b1;
                        bus_nxt    = sector_bits(flags_all,
                                                 `AE_SECTOR_FIRST);
                    end
                end
                ae_status_bus_pkg::ST_POLL_OWN: begin
                    // Hold the bus for three more cycles
                    oe_nxt     = '1;
                    sync_nxt   = sector_r == `AE_SECTOR_FIRST;
                    bus_nxt    = sector_bits(flags_all, sector_r);
                    sector_nxt = ~sector_r;
                    slot_nxt   = slot_r + 2'h1;
                    if (slot_r == `AE_MASTER_SLOTS - 2'h1) begin
                        // Hand off with a one-cycle token
                        tok_nxt   = 1'b1;
                        state_nxt = ae_status_bus_pkg::ST_POLL_WAIT;
                    end
                end
                default: begin
                    state_nxt = ae_status_bus_pkg::ST_IDLE;
                end
            endcase
        end
        ov_nxt = 1'b1;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r                    <= ae_status_bus_pkg::ST_IDLE;
            sector_r                   <= `AE_SECTOR_FIRST;
            slot_r                     <= 2'h0;
            mrs_d_r                    <= 1'b0;
            ALMOST_EMPTY_STATUS_BUS    <= `AE_BUS_RESET;
            ALMOST_EMPTY_STATUS_BUS_OE <= '0;
            EMPTY_BUS_SYNC_OUT         <= 1'b0;
            EMPTY_TOKEN_OUT            <= 1'b0;
            ACTIVE_ALMOST_EMPTY_FLAG   <= 1'b1;
            OUTPUT_VALID_FLAG          <= 1'b0;
        end else begin
            state_r                    <= state_nxt;
            sector_r                   <= sector_nxt;
            slot_r                     <= slot_nxt;
            mrs_d_r                    <= mrs_s;
            ALMOST_EMPTY_STATUS_BUS    <= bus_nxt;
            ALMOST_EMPTY_STATUS_BUS_OE <= oe_nxt;
            EMPTY_BUS_SYNC_OUT         <= sync_nxt;
            EMPTY_TOKEN_OUT            <= tok_nxt;
            ACTIVE_ALMOST_EMPTY_FLAG   <= pae_nxt;
            OUTPUT_VALID_FLAG          <= ov_nxt;
        end
    end
    // Coincident queue access may show a stale bit for one cycle

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_token_handoff;
        EMPTY_TOKEN_OUT ##1 !EMPTY_TOKEN_OUT;
    endsequence

    AST_TOKEN_ONE_CYCLE: assert property (@(posedge CLK)
        disable iff (!RESET_N) $rose(EMPTY_TOKEN_OUT) |-> s_token_handoff)
        else $error("token out longer than one cycle");

    AST_SYNC_NEEDS_OE: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        EMPTY_BUS_SYNC_OUT |-> ALMOST_EMPTY_STATUS_BUS_OE[0])
        else $error("sync high while bus not driven");

    AST_SYNC_ALTERNATES: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        EMPTY_BUS_SYNC_OUT && !EMPTY_TOKEN_OUT |=> !EMPTY_BUS_SYNC_OUT)
        else $error("sync not followed by second sector");

    sequence s_poll_take;
        state_r == ae_status_bus_pkg::ST_POLL_WAIT && !mrs_s
        && (tok_s || (chain_master_select_s && mrs_d_r));
    endsequence

    // Four owned cycles, token on the last, then release
    sequence s_poll_own;
        (ALMOST_EMPTY_STATUS_BUS_OE[0] && !EMPTY_TOKEN_OUT) [*3]
        ##1 (ALMOST_EMPTY_STATUS_BUS_OE[0] && EMPTY_TOKEN_OUT)
        ##1 !ALMOST_EMPTY_STATUS_BUS_OE[0];
    endsequence

    AST_HOLD_FOUR: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        s_poll_take |=> s_poll_own)
        else $error("polled ownership not four cycles");

    AST_MASTER_TAKES: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        state_r == ae_status_bus_pkg::ST_POLL_WAIT && !mrs_s && chain_master_select_s
        && mrs_d_r |=> EMPTY_BUS_SYNC_OUT && ALMOST_EMPTY_STATUS_BUS_OE == '1)
        else $error("master did not take bus after reset");

    AST_SMALL_FIXED: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        state_r == ae_status_bus_pkg::ST_DIRECT && !mrs_s && small_cfg
        |=> ALMOST_EMPTY_STATUS_BUS == $past(flags_all[`AE_BUS_WIDTH-1:0]))
        else $error("small config bus not fixed to first sector");

    AST_ID_IGNORED: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        state_r == ae_status_bus_pkg::ST_DIRECT && !mrs_s
        && EMPTY_SECTOR_STROBE && !id_match |=> sector_r == $past(sector_r))
        else $error("sector taken for another device");

    AST_TOKEN_RELEASE: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        EMPTY_TOKEN_OUT && !tok_s |=> !ALMOST_EMPTY_STATUS_BUS_OE[0])
        else $error("bus kept after token handed on");

    AST_DIRECT_SECTOR: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        state_r == ae_status_bus_pkg::ST_DIRECT && !mrs_s && direct_sel
        && !small_cfg |=> sector_r == $past(READ_ADDRESS_BUS[0]))
        else $error("sector not captured from address");

    AST_DIRECT_OE: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        state_r == ae_status_bus_pkg::ST_DIRECT && !mrs_s
        |=> ALMOST_EMPTY_STATUS_BUS_OE == '1)
        else $error("direct mode bus not driven");

    AST_WAIT_TRISTATE: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        state_r == ae_status_bus_pkg::ST_POLL_WAIT && !tok_s
        && !(chain_master_select_s && mrs_d_r) |=> ALMOST_EMPTY_STATUS_BUS_OE == '0)
        else $error("bus driven without token");

    AST_ACTIVE_FLAG: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        1'b1 |=> ACTIVE_ALMOST_EMPTY_FLAG
                 == $past(flags_all[READ_QUEUE_SEL]))
        else $error("active flag not tracking selected queue");

endmodule

/* File: testbench.sv */
// Self-checking bench for the almost-empty status bus
`timescale 1ns/1ps
module testbench;
    logic        clk, reset_n, master_reset_in, mode, chain_master_select, strobe, ring_on, inject;
    logic        tok_in, tok_out, sync, ae_flag, valid;
    logic [2:0]  dev_id;
    logic [4:0]  qcount;
    logic [15:0] flags;
    logic [3:0]  rsel;
    logic [5:0]  raddr;
    logic [1:0]  lag;
    logic [7:0]  bus, bus_oe, bus_wire;
    int          errors, total_checks, n;

    almost_empty_flag_status_bus DUT (
        .CLK(clk), .RESET_N(reset_n), .MASTER_RESET_IN(master_reset_in),
        .FLAG_BUS_MODE_SELECT(mode), .CHAIN_MASTER_SELECT(chain_master_select),
        .DEVICE_IDENTITY_BIT0(dev_id[0]), .DEVICE_IDENTITY_BIT1(dev_id[1]),
        .DEVICE_IDENTITY_BIT2(dev_id[2]), .QUEUE_COUNT(qcount),
        .QUEUE_ALMOST_EMPTY(flags), .READ_QUEUE_SEL(rsel),
        .READ_ADDRESS_BUS(raddr), .EMPTY_SECTOR_STROBE(strobe),
        .EMPTY_TOKEN_IN(tok_in), .ALMOST_EMPTY_STATUS_BUS(bus),
        .ALMOST_EMPTY_STATUS_BUS_OE(bus_oe),
        .ACTIVE_ALMOST_EMPTY_FLAG(ae_flag), .OUTPUT_VALID_FLAG(valid),
        .EMPTY_BUS_SYNC_OUT(sync), .EMPTY_TOKEN_OUT(tok_out));
    ae_ring_peer peer (
        .clk(clk), .ring_on(ring_on), .lag(lag), .inject(inject),
        .tok_from_dut(tok_out), .bus(bus), .bus_oe(bus_oe),
        .tok_to_dut(tok_in), .bus_wire(bus_wire));

    // ------------------------------------------------------------------
    // Checks and steps
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input logic s, input logic [5:0] a,
                        input logic [7:0] exp);
        strobe = s;
        raddr = a;
        @(posedge clk);
        #1;
        chk(bus, exp);
    endtask
    task automatic start(input logic m, input logic ms);
        reset_n = 1'b0;
        master_reset_in = 1'b1;
        mode = m;
        chain_master_select = ms;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        master_reset_in = 1'b0;
    endtask
    // Bounded wait for ownership, then both sectors twice and hand-off
    task automatic own;
        n = 0;
        while (bus_oe !== 8'hff && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(8'(n < 12), 8'h01);
        for (int k = 0; k < 4; k++) begin
            chk({7'h0, sync}, {7'h0, ~k[0]});
            chk(bus_wire, k[0] ? flags[15:8] : flags[7:0]);
            chk({7'h0, tok_out}, {7'h0, k == 3});
            @(posedge clk);
            #1;
        end
        chk(bus_oe, 8'h00);
        chk({7'h0, tok_out}, 8'h00);
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        errors++;
        summarize();
    end
    initial begin
        {reset_n, master_reset_in, mode, chain_master_select, strobe, ring_on, inject} = 7'h0;
        {dev_id, qcount, flags, rsel, raddr, lag} = {3'h5, 5'h10,
            16'h5ac3, 4'h0, 6'h00, 2'h0};
        repeat (2) @(posedge clk);
        #1;
        chk(bus, 8'hff);
        chk({bus_oe[3:0], sync, tok_out, ae_flag, valid}, 8'h02);
        start(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        #1;
        step(1'b1, 6'h29, flags[15:8]);
        step(1'b1, 6'h28, flags[7:0]);
        step(1'b1, 6'h19, flags[7:0]);
        step(1'b0, 6'h29, flags[7:0]);
        flags = 16'h3ca5;
        step(1'b1, 6'h29, 8'h3c);
        step(1'b1, 6'h28, 8'ha5);
        qcount = 5'h08;
        step(1'b1, 6'h29, flags[7:0]);
        // Queue choice never shares a cycle with a sector choice
        rsel = 4'h9;
        step(1'b0, 6'h28, flags[7:0]);
        chk({7'h0, ae_flag}, {7'h0, flags[rsel]});
        chk({7'h0, valid}, 8'h01);
        ring_on = 1'b1;
        start(1'b1, 1'b1);
        own();
        lag = 2'h3;
        own();
        own();
        ring_on = 1'b0;
        start(1'b1, 1'b0);
        n = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            n += (bus_oe !== 8'h00);
        end
        chk(8'(n), 8'h00);
        chk(bus_wire, 8'hff);
        inject = 1'b1;
        @(posedge clk);
        #1;
        inject = 1'b0;
        own();
        summarize();
    end
endmodule
